// >>> rtl/divider_and_mux_code_decoder.sv
// Purpose: decode the selected configuration set into divider ratios and sources
// Assumes: AHB-Lite single word transfers; set select arrives from pins
// Notes:   reads take two wait states, writes none
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module divider_and_mux_code_decoder (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output      logic                        hreadyout,
  output      logic [31:0]                 hrdata,
  output      logic [1:0]                  hresp,
  // set select pins
  input  wire logic [1:0]                  configSetSel,
  // decoded configuration
  output      clk_decode_pkg::decoded_type decoded,
  output      logic [1:0]                  activeSet
);

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] prescaleRatio(input logic [1:0] code);
    unique case (code)
      clk_decode_pkg::PRE_CODE_DIV3: prescaleRatio = clk_decode_pkg::PRE_RATIO_3;
      clk_decode_pkg::PRE_CODE_DIV5: prescaleRatio = clk_decode_pkg::PRE_RATIO_5;
      default:                       prescaleRatio = clk_decode_pkg::PRE_RATIO_2;
    endcase
  endfunction

  function automatic logic [6:0] bankBRatio(input logic [6:0] code);
    if (code <= clk_decode_pkg::RB_EXACT_MAX) begin
      bankBRatio = code;
    end else begin
      bankBRatio = {code[6:1], 1'b0};
    end
  endfunction

  function automatic logic setHit(input logic [31:0] a);
    setHit = (a >= clk_decode_pkg::ADDR_SET_BASE) && (a < clk_decode_pkg::ADDR_SET_END);
  endfunction

  function automatic clk_decode_pkg::clk_source_type clk_source_type_cast(input logic [1:0] c);
    clk_source_type_cast = clk_decode_pkg::clk_source_type'(c);
  endfunction

  // ----------------------------------------------------------------
  // set select synchroniser
  // ----------------------------------------------------------------
  logic [1:0] selMeta_ff;
  logic [1:0] selSync_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selMeta_ff <= 2'h0;
      selSync_ff <= 2'h0;
      activeSet  <= 2'h0;
    end else begin
      selMeta_ff <= configSetSel;
      selSync_ff <= selMeta_ff;
      activeSet  <= selSync_ff;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        accept;
  logic        wrPend_ff;
  logic [1:0]  rdStep_ff;
  logic [31:0] addr_ff;
  logic        memWrEn;
  logic [clk_decode_pkg::CFG_W-1:0] busSetWord;
  clk_decode_pkg::cfg_set_type      cfg;

  assign accept  = hsel && hready && htrans[1];
  // writes land at the end of the data phase, when hwdata is valid
  assign memWrEn = wrPend_ff && setHit(addr_ff);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_ff <= 1'b0;
      addr_ff   <= 32'h0000_0000;
    end else begin
      wrPend_ff <= accept && hwrite;
      if (accept) begin
        addr_ff <= haddr;
      end
    end
  end

  // two steps: store read on addr_ff, then result mux into hrdata
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdStep_ff <= 2'h0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else begin
      unique case (rdStep_ff)
        2'h0: begin
          if (accept && !hwrite) begin
            rdStep_ff <= 2'h1;
            hreadyout <= 1'b0;
          end
        end
        2'h1: rdStep_ff <= 2'h2;
        default: begin
          rdStep_ff <= 2'h0;
          hreadyout <= 1'b1;
          if (setHit(addr_ff)) begin
            hrdata <= 32'(busSetWord);
          end else if (addr_ff == clk_decode_pkg::ADDR_STATUS) begin
            hrdata <= 32'h0000_0000;
            hrdata[clk_decode_pkg::STAT_SET_LSB +: 2] <= activeSet;
            hrdata[clk_decode_pkg::STAT_INV_BIT]      <= decoded.invalid;
          end else if (addr_ff == clk_decode_pkg::ADDR_DECODE) begin
            hrdata <= 32'h0000_0000;
            hrdata[clk_decode_pkg::DEC_FB_LSB +: 8]   <= decoded.feedbackRatio;
            hrdata[clk_decode_pkg::DEC_TOTA_LSB +: 9] <= decoded.bankATotal;
            hrdata[clk_decode_pkg::DEC_RB_LSB +: 7]   <= decoded.bankBRatio;
            hrdata[clk_decode_pkg::DEC_PUMP_LSB +: 2] <= decoded.pumpCurrentCode;
          end else begin
            hrdata <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hresp <= clk_decode_pkg::HRESP_OKAY;
    end else begin
      hresp <= clk_decode_pkg::HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // configuration set storage
  // ----------------------------------------------------------------
  logic [clk_decode_pkg::CFG_W-1:0] activeWord;

  cfg_set_store #(
    .WIDTH      (clk_decode_pkg::CFG_W),
    .DEPTH      (clk_decode_pkg::NUM_SETS),
    .AW         (clk_decode_pkg::SEL_W),
    .RESET_WORD (clk_decode_pkg::CFG_RESET)
  ) u_store (
    .clk     (clk),
    .rstn    (rstn),
    .wrEn    (memWrEn),
    .wrAddr  (addr_ff[clk_decode_pkg::SET_IDX_LSB +: 2]),
    .wrData  (hwdata[clk_decode_pkg::CFG_W-1:0]),
    .rdAddrA (activeSet),
    .rdDataA (activeWord),
    .rdAddrB (addr_ff[clk_decode_pkg::SET_IDX_LSB +: 2]),
    .rdDataB (busSetWord)
  );

  assign cfg = clk_decode_pkg::cfg_set_type'(activeWord);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  clk_decode_pkg::decoded_type nxtDecoded;

  always_comb begin
    nxtDecoded = '0;
    // field holds divider bits 7..1; bit 0 is always zero
    nxtDecoded.feedbackRatio   = {cfg.feedbackRatioField, 1'b0};
    nxtDecoded.bankAPrescale   = prescaleRatio(cfg.bankAPrescaleCode);
    nxtDecoded.bankARatio      = cfg.bankARatioCode;
    // widen both factors first: 5 x 63 needs all nine bits
    nxtDecoded.bankATotal      = 9'(nxtDecoded.bankAPrescale) * 9'(nxtDecoded.bankARatio);
    nxtDecoded.bankBRatio      = bankBRatio(cfg.bankBRatioCode);
    // pump code passes through; matching it to the ratio is software's job
    nxtDecoded.pumpCurrentCode = cfg.pumpCurrentCode;
    nxtDecoded.bankASource     = clk_source_type_cast(cfg.bankASourceSel);
    nxtDecoded.bankBSource     = clk_source_type_cast(cfg.bankBSourceSel);
    nxtDecoded.invalid         = (cfg.feedbackRatioField < clk_decode_pkg::FB_MIN_FIELD)
                              || (cfg.bankARatioCode < clk_decode_pkg::RA_MIN_CODE)
                              || (cfg.bankBRatioCode < clk_decode_pkg::RB_MIN_CODE);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      decoded <= '0;
    end else begin
      decoded <= nxtDecoded;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [1:0] upCnt_ff;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upCnt_ff <= 2'h0;
    end else if (upCnt_ff != 2'h3) begin
      upCnt_ff <= upCnt_ff + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_fb_ratio;
    1 |=> decoded.feedbackRatio == {$past(cfg.feedbackRatioField), 1'b0};
  endproperty
  a_fb_ratio: assert property (p_fb_ratio) else $error("feedback ratio wrong");

  property p_fb_even;
    decoded.feedbackRatio[0] == 1'b0;
  endproperty
  a_fb_even: assert property (p_fb_even) else $error("feedback ratio odd");

  property p_prescale;
    cfg.bankAPrescaleCode == clk_decode_pkg::PRE_CODE_ALT2
      |=> decoded.bankAPrescale == clk_decode_pkg::PRE_RATIO_2;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale code 3 not 2");

  property p_ratio_a;
    cfg.bankARatioCode >= clk_decode_pkg::RA_MIN_CODE
      |=> decoded.bankARatio == $past(cfg.bankARatioCode);
  endproperty
  a_ratio_a: assert property (p_ratio_a) else $error("bank A ratio wrong");

  property p_total_a;
    1 |=> decoded.bankATotal == 9'($past(cfg.bankARatioCode))
      * (($past(cfg.bankAPrescaleCode) == clk_decode_pkg::PRE_CODE_DIV3)
         ? 9'(clk_decode_pkg::PRE_RATIO_3)
         : ($past(cfg.bankAPrescaleCode) == clk_decode_pkg::PRE_CODE_DIV5)
         ? 9'(clk_decode_pkg::PRE_RATIO_5)
         : 9'(clk_decode_pkg::PRE_RATIO_2));
  endproperty
  a_total_a: assert property (p_total_a) else $error("bank A total wrong");

  property p_ratio_b_exact;
    (cfg.bankBRatioCode >= clk_decode_pkg::RB_MIN_CODE)
      && (cfg.bankBRatioCode <= clk_decode_pkg::RB_EXACT_MAX)
      |=> decoded.bankBRatio == $past(cfg.bankBRatioCode);
  endproperty
  a_ratio_b_exact: assert property (p_ratio_b_exact) else $error("bank B exact wrong");

  property p_ratio_b_even;
    cfg.bankBRatioCode > clk_decode_pkg::RB_EXACT_MAX
      |=> decoded.bankBRatio == {$past(cfg.bankBRatioCode[6:1]), 1'b0};
  endproperty
  a_ratio_b_even: assert property (p_ratio_b_even) else $error("bank B even wrong");

  property p_src_a;
    1 |=> decoded.bankASource == $past(cfg.bankASourceSel);
  endproperty
  a_src_a: assert property (p_src_a) else $error("bank A source wrong");

  property p_src_b;
    1 |=> decoded.bankBSource == $past(cfg.bankBSourceSel);
  endproperty
  a_src_b: assert property (p_src_b) else $error("bank B source wrong");

  property p_set_follow;
    upCnt_ff == 2'h3 |-> activeSet == $past(configSetSel, 3);
  endproperty
  a_set_follow: assert property (p_set_follow) else $error("active set lags pins");

  property p_invalid;
    (cfg.bankARatioCode < clk_decode_pkg::RA_MIN_CODE)
      || (cfg.feedbackRatioField < clk_decode_pkg::FB_MIN_FIELD)
      || (cfg.bankBRatioCode < clk_decode_pkg::RB_MIN_CODE)
      |=> decoded.invalid;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code not flagged");

endmodule // divider_and_mux_code_decoder

// >>> rtl/clk_decode_pkg.sv
// Purpose: shared constants and types for the divider and source code decoder
// Assumes: four configuration sets, each one 28-bit word on the register bus
// Notes:   field order inside a set word follows the struct packing below
package clk_decode_pkg;

  // ----------------------------------------------------------------
  // field widths and counts
  // ----------------------------------------------------------------
  localparam int NUM_SETS = 4;
  localparam int SEL_W    = 2;

  typedef struct packed {
    logic [1:0] bankBSourceSel;
    logic [1:0] bankASourceSel;
    logic [1:0] pumpCurrentCode;
    logic [6:0] bankBRatioCode;
    logic [5:0] bankARatioCode;
    logic [1:0] bankAPrescaleCode;
    logic [6:0] feedbackRatioField;
  } cfg_set_type;

  localparam int CFG_W = $bits(cfg_set_type);

  typedef enum logic [1:0] {
    SRC_CRYSTAL,
    SRC_REF_DIFF,
    SRC_DIVIDER_A,
    SRC_DIVIDER_B
  } clk_source_type;

  typedef struct packed {
    logic [7:0]     feedbackRatio;
    logic [2:0]     bankAPrescale;
    logic [5:0]     bankARatio;
    logic [8:0]     bankATotal;
    logic [6:0]     bankBRatio;
    logic [1:0]     pumpCurrentCode;
    clk_source_type bankASource;
    clk_source_type bankBSource;
    logic           invalid;
  } decoded_type;

  // ----------------------------------------------------------------
  // code limits and ratios
  // ----------------------------------------------------------------
  localparam logic [6:0] FB_MIN_FIELD   = 7'h08;
  localparam logic [5:0] RA_MIN_CODE    = 6'h02;
  localparam logic [6:0] RB_MIN_CODE    = 7'h02;
  localparam logic [6:0] RB_EXACT_MAX   = 7'h05;
  localparam logic [1:0] PRE_CODE_DIV2  = 2'h0;
  localparam logic [1:0] PRE_CODE_DIV3  = 2'h1;
  localparam logic [1:0] PRE_CODE_DIV5  = 2'h2;
  localparam logic [1:0] PRE_CODE_ALT2  = 2'h3;
  localparam logic [2:0] PRE_RATIO_2    = 3'h2;
  localparam logic [2:0] PRE_RATIO_3    = 3'h3;
  localparam logic [2:0] PRE_RATIO_5    = 3'h5;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_SET_BASE = 32'h0000_0000;
  localparam logic [31:0] ADDR_SET_END  = 32'h0000_0010;
  localparam logic [31:0] ADDR_STATUS   = 32'h0000_0014;
  localparam logic [31:0] ADDR_DECODE   = 32'h0000_0018;
  localparam int          SET_IDX_LSB   = 2;
  localparam int          STAT_SET_LSB  = 0;
  localparam int          STAT_INV_BIT  = 2;
  localparam int          DEC_FB_LSB    = 0;
  localparam int          DEC_TOTA_LSB  = 8;
  localparam int          DEC_RB_LSB    = 17;
  localparam int          DEC_PUMP_LSB  = 24;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  // set contents after reset: feedback 160, bank A 2*8, bank B 8
  localparam cfg_set_type CFG_RESET = '{
    bankBSourceSel:     2'h3,
    bankASourceSel:     2'h2,
    pumpCurrentCode:    2'h2,
    bankBRatioCode:     7'h08,
    bankARatioCode:     6'h08,
    bankAPrescaleCode:  2'h0,
    feedbackRatioField: 7'h50
  };

endpackage

// >>> rtl/cfg_set_store.sv
// Purpose: storage for the configuration sets, one write and two read ports
// Assumes: single clock; read data registered
// Notes:   a write and a read of one entry in one cycle return the old word
`timescale 1ns/1ps
module cfg_set_store #(
  parameter int                 WIDTH      = 28,
  parameter int                 DEPTH      = 4,
  parameter int                 AW         = 2,
  parameter logic [WIDTH-1:0]   RESET_WORD = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read ports
  input  wire logic [AW-1:0]    rdAddrA,
  output      logic [WIDTH-1:0] rdDataA,
  input  wire logic [AW-1:0]    rdAddrB,
  output      logic [WIDTH-1:0] rdDataB
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= RESET_WORD;
      end
    end else if (wrEn) begin
      mem_ff[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdDataA <= RESET_WORD;
      rdDataB <= RESET_WORD;
    end else begin
      rdDataA <= mem_ff[rdAddrA];
      rdDataB <= mem_ff[rdAddrB];
    end
  end

endmodule // cfg_set_store

// >>> test/tb.sv
// Purpose: self-checking bench for the divider and source code decoder
// Assumes: AHB-Lite single word transfers, hready tied to hreadyout
// Notes:   decoded outputs are given a fixed 10-cycle settle after a change
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int         TIMEOUT     = 20000;
  localparam logic [6:0] FB_TAB [12] = '{7'h08, 7'h7D, 7'h07, 7'h10, 7'h20, 7'h50,
                                         7'h60, 7'h7C, 7'h18, 7'h30, 7'h40, 7'h7D};
  localparam logic [5:0] RA_TAB [12] = '{6'h3F, 6'h3F, 6'h3F, 6'h3F, 6'h00, 6'h01,
                                         6'h02, 6'h03, 6'h10, 6'h20, 6'h3E, 6'h3F};
  localparam logic [6:0] RB_TAB [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
                                         7'h06, 7'h07, 7'h08, 7'h7E, 7'h7F, 7'h0C};
  logic                        clk          = 1'b0;
  logic                        rstn         = 1'b0;
  logic                        hsel         = 1'b0;
  logic [31:0]                 haddr        = '0;
  logic [1:0]                  htrans       = '0;
  logic                        hwrite       = 1'b0;
  logic [2:0]                  hsize        = 3'h2;
  logic [31:0]                 hwdata       = '0;
  logic [1:0]                  configSetSel = '0;
  logic                        hreadyout;
  logic [31:0]                 hrdata;
  logic [1:0]                  hresp;
  logic [1:0]                  activeSet;
  clk_decode_pkg::decoded_type decoded;
  clk_decode_pkg::cfg_set_type mem [4];
  int                          mismatches   = 0;
  int                          check_count  = 0;
  int                          cycleCount   = 0;

  always #5 clk = ~clk;

  divider_and_mux_code_decoder i_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .configSetSel(configSetSel), .decoded(decoded), .activeSet(activeSet)
  );

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] expv, input string msg);
    check_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, expv);
    end
  endtask

  // hang on a silent slave is cut short by the cycle ceiling
  task automatic busXfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    check(hresp, clk_decode_pkg::HRESP_OKAY, "hresp");
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    busXfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    busXfer(1'b0, a, '0, d);
  endtask

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic clk_decode_pkg::decoded_type expDec(clk_decode_pkg::cfg_set_type c);
    clk_decode_pkg::decoded_type d;
    d.feedbackRatio = {c.feedbackRatioField, 1'b0};
    case (c.bankAPrescaleCode)
      2'h1: d.bankAPrescale = 3'h3;
      2'h2: d.bankAPrescale = 3'h5;
      default: d.bankAPrescale = 3'h2;
    endcase
    d.bankARatio = c.bankARatioCode;
    d.bankATotal = {6'h00, d.bankAPrescale} * {3'h0, d.bankARatio};
    d.bankBRatio = (c.bankBRatioCode > 7'h05) ? {c.bankBRatioCode[6:1], 1'b0}
                                              : c.bankBRatioCode;
    d.pumpCurrentCode = c.pumpCurrentCode;
    d.bankASource = clk_decode_pkg::clk_source_type'(c.bankASourceSel);
    d.bankBSource = clk_decode_pkg::clk_source_type'(c.bankBSourceSel);
    d.invalid = (c.feedbackRatioField < 7'h08) || (c.bankARatioCode < 6'h02) ||
                (c.bankBRatioCode < 7'h02);
    return d;
  endfunction

  // bandwidth code for a feedback ratio, as software has to pick it
  function automatic logic [1:0] pumpFor(logic [7:0] r);
    return (r < 8'd48) ? 2'h0 : (r < 8'd100) ? 2'h1 : (r < 8'd192) ? 2'h2 : 2'h3;
  endfunction

  task automatic checkAll(input logic [1:0] s);
    clk_decode_pkg::decoded_type e;
    logic [31:0]                 r;
    e = expDec(mem[s]);
    repeat (10) @(posedge clk);
    check(activeSet, s, "active set");
    check(decoded.feedbackRatio, e.feedbackRatio, "fb ratio");
    check({decoded.bankAPrescale, decoded.bankARatio}, {e.bankAPrescale, e.bankARatio},
          "bank a");
    check(decoded.bankATotal, e.bankATotal, "bank a total");
    check(decoded.bankBRatio, e.bankBRatio, "bank b");
    check(decoded.pumpCurrentCode, e.pumpCurrentCode, "pump");
    check({decoded.bankASource, decoded.bankBSource}, {e.bankASource, e.bankBSource},
          "sources");
    check(decoded.invalid, e.invalid, "invalid");
    rd(clk_decode_pkg::ADDR_STATUS, r);
    check(r, {29'h0, e.invalid, s}, "status");
    rd(clk_decode_pkg::ADDR_DECODE, r);
    check(r, {6'h00, e.pumpCurrentCode, e.bankBRatio, e.bankATotal, e.feedbackRatio},
          "decode reg");
    rd({28'h0, s, 2'h0}, r);
    check(r, {4'h0, mem[s]}, "set word");
  endtask

  // ------------------------------------------------------------
  // timeout and main sequence
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == TIMEOUT) begin
      mismatches++;
      results();
    end
  end

  initial begin
    logic [31:0]                 r;
    logic [1:0]                  s;
    logic [1:0]                  cur;
    clk_decode_pkg::cfg_set_type c;
    void'($urandom(7649));
    cur = 2'h0;
    for (int i = 0; i < 4; i++)
      mem[i] = clk_decode_pkg::CFG_RESET;
    // flops hold unknown until the first edge under reset
    @(posedge clk);
    #1 check(decoded, '0, "decoded in reset");
    check(hreadyout, 1'b1, "ready in reset");
    @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(32'(4 * i), r);
      check(r, {4'h0, clk_decode_pkg::CFG_RESET}, "reset set word");
    end
    checkAll(cur);
    // corner codes: every prescale, source and pump code, divider edges
    for (int i = 0; i < 12; i++) begin
      c.feedbackRatioField = FB_TAB[i];
      c.bankAPrescaleCode  = 2'(i);
      c.bankARatioCode     = RA_TAB[i];
      c.bankBRatioCode     = RB_TAB[i];
      c.pumpCurrentCode    = pumpFor({FB_TAB[i], 1'b0});
      c.bankASourceSel     = 2'(i);
      c.bankBSourceSel     = 2'(3 - i);
      cur = 2'(i);
      wr({28'h0, cur, 2'h0}, {4'hF, c});
      mem[cur] = c;
      configSetSel <= cur;
      checkAll(cur);
    end
    // random writes to any set mixed with set switches
    for (int i = 0; i < 60; i++) begin
      s = 2'($urandom);
      if ($urandom % 2) begin
        c = 28'($urandom);
        c.pumpCurrentCode = pumpFor({c.feedbackRatioField, 1'b0});
        wr({28'h0, s, 2'h0}, {4'h0, c});
        mem[s] = c;
        rd({28'h0, s, 2'h0}, r);
        check(r, {4'h0, c}, "write then read");
      end else begin
        cur = s;
        configSetSel <= s;
      end
      checkAll(cur);
    end
    // read-only and unmapped places must not change anything
    wr(clk_decode_pkg::ADDR_STATUS, $urandom);
    wr(clk_decode_pkg::ADDR_DECODE, $urandom);
    wr(clk_decode_pkg::ADDR_SET_END, $urandom);
    wr(32'h0000_0020, $urandom);
    rd(clk_decode_pkg::ADDR_SET_END, r);
    check(r, 32'h0, "unmapped read");
    rd(32'h0000_0020, r);
    check(r, 32'h0, "unmapped read");
    checkAll(cur);
    results();
  end
endmodule // tb
